// file: hdl/rsa_pkg.sv
// Constants, field layout and types for the receive status and
// end-of-packet block. Assumes a 100 MHz system clock and a slower
// receive FIFO read clock that arrives as a plain pin.
package rsa_pkg;
   // ===========================================================
   // Sizes
   localparam int NPORT     = 4;
   localparam int LVL_W     = 12;
   localparam int CNT_W     = 5;
   // ===========================================================
   // Register byte addresses
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] THRESH_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   // ===========================================================
   // Control register fields
   localparam int CTRL_PKT_BIT   = 0;
   localparam int CTRL_LVL_BIT   = 1;
   localparam int CTRL_INV_BIT   = 2;
   localparam int CTRL_ADR_LSB   = 4;
   localparam int CTRL_OEN_BIT   = 8;
   // ===========================================================
   // Reset values
   localparam logic             PKT_MODE_RST = 1'b0;
   localparam logic             LVL_SEL_RST  = 1'b1;
   localparam logic             INVERT_RST   = 1'b0;
   localparam logic [2:0]       ADR_CFG_RST  = 3'h0;
   localparam logic             OEN_RST      = 1'b0;
   localparam logic [LVL_W-1:0] THRESH_RST   = 12'h040;
   // ===========================================================
   // Cell counting and addresses
   localparam logic [CNT_W-1:0] HDR_WORDS    = 5'h03;
   localparam logic [CNT_W-1:0] LAST_WORD_HI = 5'h18; // Payload word 24
   localparam logic [CNT_W-1:0] LAST_WORD_LO = 5'h13; // Payload word 19
   localparam logic [4:0]       NULL_ADDR    = 5'h1f;
   localparam logic [CNT_W-1:0] SOP_COUNT    = 5'h01; // First word of a cell
   // ===========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ===========================================================
   // Bus state machines
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_TAKE = 2'b01,
      BUS_RESP = 2'b10
   } rsa_bus_t;
endpackage : rsa_pkg

// file: hdl/rsa_status_eop.sv
// Receive-side direct availability outputs and packet end markers.
// Assumes same-clock FIFO status and word information from the receive
// data path; read clock, enable and address arrive as raw pins.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module rsa_status_eop
   import rsa_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  srst,
   // AXI4-Lite slave
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Link pins, asynchronous to clk
   input  wire logic                  rfclk,
   input  wire logic                  renb_n,
   input  wire logic [4:0]            radr,
   input  wire logic                  sys_if_out_enable_pin,
   // FIFO status from the receive data path
   input  wire logic [NPORT-1:0]      cell_ready,
   input  wire logic [NPORT-1:0]      cell_more,
   input  wire logic [NPORT-1:0]      pkt_end_held,
   input  wire logic [NPORT*LVL_W-1:0] fifo_level,
   // Word put on the data bus at the coming read clock edge
   input  wire logic                  word_strobe,
   input  wire logic                  word_sop,
   input  wire logic                  word_eop,
   input  wire logic                  word_single,
   // Pins
   output logic [NPORT-1:0]           direct_avail,
   output logic                       rmod_o,
   output logic                       rmod_oe_n,
   output logic                       reop_o,
   output logic                       reop_oe_n
);
   // ===========================================================
   // State
   typedef struct packed {
      logic [2:0]          rf_sync;
      logic [1:0]          en_sync;
      logic [9:0]          adr_sync;
      logic [4:0]          sel_addr;
      logic [CNT_W-1:0]    word_cnt;
      logic [1:0]          oen_sync;
      logic                pend_word;
      logic                pend_sop;
      logic                pend_eop;
      logic                pend_single;
      logic [NPORT-1:0]    avail;
      logic                rmod;
      logic                rmod_oe_n;
      logic                reop;
      logic                reop_oe_n;
      logic                pkt_mode;
      logic                lvl_sel;
      logic                invert;
      logic [2:0]          adr_cfg;
      logic                oen_bit;
      logic [LVL_W-1:0]    thresh;
      rsa_bus_t            wst;
      logic [7:0]          waddr;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      rsa_bus_t            rst;
      logic                arready;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
   } rsa_state_t;

   rsa_state_t st_r;
   rsa_state_t st_nxt;

   logic       rf_rise;
   logic       en_act;
   logic [4:0] polled;
   logic       sel_ok;
   logic       drive;
   logic [CNT_W-1:0] last_word;

   // ===========================================================
   // Decoded link conditions
   assign rf_rise   = st_r.rf_sync[1] & ~st_r.rf_sync[2];
   assign en_act    = ~st_r.en_sync[1];
   assign polled    = st_r.adr_sync[9:5];
   assign sel_ok    = (st_r.sel_addr != NULL_ADDR) &&
                      (st_r.sel_addr[4:2] == st_r.adr_cfg);
   assign last_word = st_r.lvl_sel ? LAST_WORD_HI : LAST_WORD_LO;
   assign drive     = en_act & sel_ok & st_r.pkt_mode &
                      (st_r.oen_bit | st_r.oen_sync[1]);

   // ===========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      // Pins pass two flip-flops before use
      st_nxt.rf_sync  = {st_r.rf_sync[1:0], rfclk};
      st_nxt.en_sync  = {st_r.en_sync[0], renb_n};
      st_nxt.adr_sync = {st_r.adr_sync[4:0], radr};
      st_nxt.oen_sync = {st_r.oen_sync[0], sys_if_out_enable_pin};

      // Word information waits for the next read clock edge, so a
      // one-cycle strobe is never lost between two slow edges
      if (word_strobe) begin
         st_nxt.pend_word   = 1'b1;
         st_nxt.pend_sop    = word_sop;
         st_nxt.pend_eop    = word_eop;
         st_nxt.pend_single = word_single & word_eop;
      end

      if (rf_rise) begin
         // Address latched while the enable is deasserted
         if (!en_act) begin
            st_nxt.sel_addr = polled;
         end
         // Count words of the cell in transfer; the first word counts
         // as one, so payload word N ends at count N plus the header
         if (st_r.pend_word && st_r.pend_sop) begin
            st_nxt.word_cnt = SOP_COUNT;
         end else if (st_r.pend_word && st_r.word_cnt != '1) begin
            st_nxt.word_cnt = st_r.word_cnt + 5'h01;
         end
         // Availability outputs, shared by both modes
         for (int p = 0; p < NPORT; p++) begin
            if (st_r.pkt_mode) begin
               st_nxt.avail[p] = (pkt_end_held[p] ||
                  fifo_level[p*LVL_W +: LVL_W] >= st_r.thresh)
                  ^ st_r.invert;
            end else if (sel_ok && polled == st_r.sel_addr &&
                         st_r.sel_addr[1:0] == p[1:0] &&
                         st_r.word_cnt >= last_word + HDR_WORDS &&
                         !cell_more[p]) begin
               st_nxt.avail[p] = 1'b0;
            end else begin
               st_nxt.avail[p] = cell_ready[p];
            end
         end
         // End marker and modulo, floated unless selected and enabled
         st_nxt.rmod_oe_n = ~drive;
         st_nxt.reop_oe_n = ~drive;
         st_nxt.reop = drive & st_r.pend_eop;
         // Modulo gives the length of the final word only
         st_nxt.rmod = drive & st_r.pend_eop &
                       st_r.pend_single;
         // The pending word is used up at this edge; a strobe in the
         // same cycle wins and waits for the following edge. End
         // information stays until a selected port presents it.
         if (!word_strobe) begin
            st_nxt.pend_word = 1'b0;
            st_nxt.pend_sop  = 1'b0;
            if (drive) begin
               st_nxt.pend_eop    = 1'b0;
               st_nxt.pend_single = 1'b0;
            end
         end
      end

      // Write channel: address and data taken together
      st_nxt.awready = 1'b0;
      st_nxt.wready  = 1'b0;
      case (st_r.wst)
         BUS_IDLE: begin
            if (s_axi_awvalid && s_axi_wvalid) begin
               st_nxt.awready = 1'b1;
               st_nxt.wready  = 1'b1;
               st_nxt.waddr   = s_axi_awaddr;
               st_nxt.wst     = BUS_TAKE;
            end
         end
         BUS_TAKE: begin
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = RESP_OKAY;
            st_nxt.wst    = BUS_RESP;
            if (st_r.waddr == CTRL_OFS) begin
               if (s_axi_wstrb[0]) begin
                  st_nxt.pkt_mode = s_axi_wdata[CTRL_PKT_BIT];
                  st_nxt.lvl_sel  = s_axi_wdata[CTRL_LVL_BIT];
                  st_nxt.invert   = s_axi_wdata[CTRL_INV_BIT];
                  st_nxt.adr_cfg  = s_axi_wdata[CTRL_ADR_LSB +: 3];
               end
               if (s_axi_wstrb[1]) begin
                  st_nxt.oen_bit = s_axi_wdata[CTRL_OEN_BIT];
               end
            end else if (st_r.waddr == THRESH_OFS) begin
               if (s_axi_wstrb[0]) begin
                  st_nxt.thresh[7:0] = s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  st_nxt.thresh[11:8] = s_axi_wdata[11:8];
               end
            end else if (st_r.waddr != STATUS_OFS) begin
               st_nxt.bresp = RESP_SLVERR;
            end
         end
         BUS_RESP: begin
            if (s_axi_bready) begin
               st_nxt.bvalid = 1'b0;
               st_nxt.wst    = BUS_IDLE;
            end
         end
         default: begin
            st_nxt.wst = BUS_IDLE;
         end
      endcase

      // Read channel
      st_nxt.arready = 1'b0;
      case (st_r.rst)
         BUS_IDLE: begin
            if (s_axi_arvalid) begin
               st_nxt.arready = 1'b1;
               st_nxt.rvalid  = 1'b1;
               st_nxt.rresp   = RESP_OKAY;
               st_nxt.rdata   = '0;
               st_nxt.rst     = BUS_RESP;
               case (s_axi_araddr)
                  CTRL_OFS: begin
                     st_nxt.rdata[CTRL_PKT_BIT]     = st_r.pkt_mode;
                     st_nxt.rdata[CTRL_LVL_BIT]     = st_r.lvl_sel;
                     st_nxt.rdata[CTRL_INV_BIT]     = st_r.invert;
                     st_nxt.rdata[CTRL_ADR_LSB +: 3] = st_r.adr_cfg;
                     st_nxt.rdata[CTRL_OEN_BIT]     = st_r.oen_bit;
                  end
                  THRESH_OFS: begin
                     st_nxt.rdata[LVL_W-1:0] = st_r.thresh;
                  end
                  STATUS_OFS: begin
                     st_nxt.rdata[3:0]   = st_r.avail;
                     st_nxt.rdata[4]     = st_r.reop;
                     st_nxt.rdata[5]     = st_r.rmod;
                     st_nxt.rdata[12:8]  = st_r.sel_addr;
                     st_nxt.rdata[20:16] = st_r.word_cnt;
                  end
                  default: begin
                     st_nxt.rresp = RESP_SLVERR;
                  end
               endcase
            end
         end
         BUS_RESP: begin
            if (s_axi_rready) begin
               st_nxt.rvalid = 1'b0;
               st_nxt.rst    = BUS_IDLE;
            end
         end
         default: begin
            st_nxt.rst = BUS_IDLE;
         end
      endcase
   end

   // ===========================================================
   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r           <= '0;
         st_r.en_sync   <= 2'h3;
         st_r.sel_addr  <= NULL_ADDR;
         st_r.rmod_oe_n <= 1'b1;
         st_r.reop_oe_n <= 1'b1;
         st_r.pkt_mode  <= PKT_MODE_RST;
         st_r.lvl_sel   <= LVL_SEL_RST;
         st_r.invert    <= INVERT_RST;
         st_r.adr_cfg   <= ADR_CFG_RST;
         st_r.oen_bit   <= OEN_RST;
         st_r.thresh    <= THRESH_RST;
         st_r.wst       <= BUS_IDLE;
         st_r.rst       <= BUS_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ===========================================================
   // Outputs straight from flip-flops; availability has no enable
   assign direct_avail  = st_r.avail;
   assign rmod_o        = st_r.rmod;
   assign rmod_oe_n     = st_r.rmod_oe_n;
   assign reop_o        = st_r.reop;
   assign reop_oe_n     = st_r.reop_oe_n;
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready  = st_r.wready;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;

   // ===========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence edge_seen;
      rf_rise;
   endsequence

   sequence idle_enable;
      edge_seen and !en_act;
   endsequence

   avail_on_edge_a: assert property (
      !$stable(direct_avail) |-> $past(rf_rise))
      else $error("Availability changed away from a read clock edge");

   markers_on_edge_a: assert property (
      (!$stable(rmod_o) || !$stable(reop_o)) |-> $past(rf_rise))
      else $error("Modulo or end marker changed off an edge");

   idle_float_a: assert property (
      idle_enable |=> rmod_oe_n && reop_oe_n)
      else $error("Markers driven with enable deasserted");

   null_float_a: assert property (
      (edge_seen and (st_r.sel_addr == NULL_ADDR)) |=>
      rmod_oe_n && reop_oe_n)
      else $error("Markers driven for the null address");

   cell_float_a: assert property (
      (edge_seen and !st_r.pkt_mode) |=> rmod_oe_n && reop_oe_n)
      else $error("Markers driven in cell mode");

   pkt_avail_a: assert property (
      (edge_seen and st_r.pkt_mode) |=>
      direct_avail[0] == (($past(pkt_end_held[0]) ||
         $past(fifo_level[LVL_W-1:0]) >= $past(st_r.thresh))
         ^ $past(st_r.invert)))
      else $error("Packet availability wrong for port 0");

   last_word_a: assert property (
      (edge_seen and drive and st_r.pend_eop) |=>
      reop_o && !reop_oe_n && rmod_o == $past(st_r.pend_single))
      else $error("End marker or modulo wrong on final word");

   rmod_with_eop_a: assert property (
      rmod_o |-> reop_o)
      else $error("Modulo high outside a final word");

   cell_plain_a: assert property (
      (edge_seen and !st_r.pkt_mode and (polled != st_r.sel_addr)) |=>
      direct_avail == $past(cell_ready))
      else $error("Cell availability does not follow the FIFO");

   cell_early_a: assert property (
      (edge_seen and !st_r.pkt_mode and sel_ok and
       (polled == st_r.sel_addr) and
       (st_r.word_cnt >= last_word + HDR_WORDS) and
       !cell_more[st_r.sel_addr[1:0]]) |=>
      !direct_avail[$past(st_r.sel_addr[1:0])])
      else $error("Cell availability did not drop after last word");

   sequence first_word;
      edge_seen and st_r.pend_word and st_r.pend_sop;
   endsequence

   count_start_a: assert property (
      first_word |=> st_r.word_cnt == SOP_COUNT)
      else $error("Word count did not restart on a first word");

   strobe_kept_a: assert property (
      (word_strobe && word_eop) |=> st_r.pend_eop)
      else $error("End of packet strobe was lost");

endmodule : rsa_status_eop

// file: tb/rsa_llc_model.sv
// Link layer controller model: read clock, read enable and address.
// Assumes the bench raises run once reset is over and keeps it high.
`timescale 1ns/1ps
module rsa_llc_model (
   input  wire logic       run,
   input  wire logic       sel_en,
   input  wire logic [4:0] sel_addr,
   input  wire logic       reop_o,
   input  wire logic       reop_oe_n,
   output logic            rfclk,
   output logic            renb_n,
   output logic [4:0]      radr,
   output int              eop_seen
);
   // ==========================================================
   // Read clock
   // Period 160 ns, well under the 50 MHz ceiling
   initial rfclk = 1'b0;
   always #80 if (run) rfclk = ~rfclk;

   // ==========================================================
   // Selection
   // Enable and address move on the falling edge, away from sampling
   initial begin
      renb_n = 1'b1;
      radr   = 5'h1f;
   end
   always @(negedge rfclk) begin
      renb_n <= ~sel_en;
      radr   <= sel_addr;
   end

   // End markers count only while the port drives them
   initial eop_seen = 0;
   always @(posedge rfclk) begin
      if (!reop_oe_n && reop_o === 1'b1) eop_seen <= eop_seen + 1;
   end
endmodule : rsa_llc_model

// file: tb/rsa_status_eop_test.sv
// Bench for the receive status and end-of-packet block.
// Assumes the controller model makes the read clock, enable and address.
`timescale 1ns/1ps
module rsa_status_eop_test;
   import rsa_pkg::*;
   // ==========================================================
   // Signals and instances
   logic                   clk = 1'b0, srst = 1'b1, run = 1'b0;
   logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]            wdata = 32'h0, rdata;
   logic [3:0]             wstrb = 4'hf;
   logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                   arvalid = 1'b0, rready = 1'b0;
   logic                   awready, wready, bvalid, arready, rvalid;
   logic [1:0]             bresp, rresp;
   logic                   rfclk, renb_n, sel_en = 1'b0, oen_pin = 1'b1;
   logic [4:0]             radr, sel_addr = 5'h1f;
   logic [NPORT-1:0]       c_rdy = 4'h0, c_more = 4'h0, p_end = 4'h0, d_av;
   logic [NPORT*LVL_W-1:0] level = 48'h0;
   logic                   w_stb = 1'b0, w_sop = 1'b0;
   logic                   w_eop = 1'b0, w_sgl = 1'b0;
   logic                   rmod, rmod_oe_n, reop, reop_oe_n;
   int                     err_total = 0, check_count = 0, eops;

   rsa_status_eop dut_u (
      .clk(clk), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .rfclk(rfclk), .renb_n(renb_n), .radr(radr),
      .sys_if_out_enable_pin(oen_pin), .cell_ready(c_rdy),
      .cell_more(c_more), .pkt_end_held(p_end), .fifo_level(level),
      .word_strobe(w_stb), .word_sop(w_sop), .word_eop(w_eop),
      .word_single(w_sgl), .direct_avail(d_av), .rmod_o(rmod),
      .rmod_oe_n(rmod_oe_n), .reop_o(reop), .reop_oe_n(reop_oe_n));

   rsa_llc_model llc_u (
      .run(run), .sel_en(sel_en), .sel_addr(sel_addr), .reop_o(reop),
      .reop_oe_n(reop_oe_n), .rfclk(rfclk), .renb_n(renb_n),
      .radr(radr), .eop_seen(eops));

   // System clock, 100 MHz
   always #5 clk = ~clk;

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Bus write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n = 0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 40);
      chk(bvalid, 32'h1);
      chk(bresp, er);
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   // Bus read: data and response taken at the valid edge
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      chk(rvalid, 32'h1);
      chk(rdata, ed);
      chk(rresp, er);
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   // One read clock rise; v is strobe, sop, eop, single byte
   task automatic tick(input logic [3:0] v);
      {w_stb, w_sop, w_eop, w_sgl} <= v;
      @(posedge clk);
      w_stb <= 1'b0;
      @(posedge rfclk);
      repeat (6) @(posedge clk);
   endtask : tick

   // Latch an address with enable off, then assert the enable
   task automatic sel(input logic [4:0] a);
      sel_addr <= a;
      sel_en   <= 1'b0;
      tick(4'h0);
      tick(4'h0);
      sel_en <= 1'b1;
      tick(4'h0);
   endtask : sel

   // ==========================================================
   // Scenarios
   task automatic t_regs;
      rd(CTRL_OFS, 32'h2, RESP_OKAY);
      rd(THRESH_OFS, 32'h40, RESP_OKAY);
      rd(8'h0c, 32'h0, RESP_SLVERR);
      wr(8'h0c, 32'h1, RESP_SLVERR);
      wr(STATUS_OFS, 32'h0, RESP_OKAY);
      wr(THRESH_OFS, 32'h20, RESP_OKAY);
      rd(THRESH_OFS, 32'h20, RESP_OKAY);
   endtask : t_regs

   // One cell word by word; port 1 must drop at the edge after the
   // given word count, header words included
   task automatic cell_run(input int last);
      for (int i = 1; i <= last; i++) begin
         tick({1'b1, i == 1, 2'b00});
         if (i == last) chk(d_av[1], 32'h1);
      end
      tick(4'h0);
      chk(d_av[1], 32'h0);
   endtask : cell_run

   task automatic t_cell;
      wr(CTRL_OFS, 32'h0, RESP_OKAY);
      c_rdy <= 4'ha;
      tick(4'h0);
      chk(d_av, 32'ha);
      chk(reop_oe_n, 32'h1);
      c_rdy <= 4'he;
      repeat (3) @(posedge clk);
      chk(d_av, 32'ha);
      tick(4'h0);
      chk(d_av, 32'he);
      sel(5'h01);
      cell_run(22);
      // A second cell queued keeps the output high
      c_more <= 4'h2;
      tick(4'h0);
      chk(d_av[1], 32'h1);
      // Polling another port leaves the selected port's output alone
      c_more   <= 4'h0;
      sel_addr <= 5'h02;
      tick(4'h0);
      chk(d_av[1], 32'h1);
      // Level bit set: drop after payload word 24
      wr(CTRL_OFS, 32'h2, RESP_OKAY);
      sel_addr <= 5'h01;
      cell_run(27);
   endtask : t_cell

   task automatic t_pkt;
      wr(THRESH_OFS, 32'h40, RESP_OKAY);
      wr(CTRL_OFS, 32'h1, RESP_OKAY);
      p_end <= 4'h1;
      level <= {12'h000, 12'h03f, 12'h040, 12'h000};
      tick(4'h0);
      chk(d_av, 32'h3);
      wr(CTRL_OFS, 32'h5, RESP_OKAY);
      oen_pin <= 1'b0;
      tick(4'h0);
      chk(d_av, 32'hc);
   endtask : t_pkt

   task automatic t_eop;
      logic [4:0] bad [2] = '{5'h1f, 5'h05};
      wr(CTRL_OFS, 32'h1, RESP_OKAY);
      oen_pin <= 1'b1;
      sel(5'h01);
      tick(4'hf);
      chk({reop_oe_n, reop, rmod}, 32'h3);
      tick(4'hc);
      chk({reop_oe_n, reop}, 32'h0);
      tick(4'ha);
      chk({rmod_oe_n, reop, rmod}, 32'h2);
      tick(4'h0);
      chk({reop_oe_n, reop}, 32'h0);
      chk(eops, 32'h2);
      sel_en <= 1'b0;
      tick(4'h0);
      chk({rmod_oe_n, reop_oe_n}, 32'h3);
      foreach (bad[k]) begin
         sel(bad[k]);
         chk({rmod_oe_n, reop_oe_n}, 32'h3);
      end
   endtask : t_eop

   // ==========================================================
   // Run
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // Main sequence after a 20 cycle reset
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      run  <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_cell();
      t_pkt();
      t_eop();
      print_verdict();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule : rsa_status_eop_test
